// >>> spd_regs.svh
// constants for the serial programming command decoder
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH

// ****************************************
// opcodes, byte one
// ****************************************
`define SPD_OP_PREFIX_AC 8'hac
`define SPD_OP_POLL 8'hf0
`define SPD_OP_LOAD_EXT 8'h4d
`define SPD_OP_LOAD_HI 8'h48
`define SPD_OP_LOAD_LO 8'h40
`define SPD_OP_LOAD_EE 8'hc1
`define SPD_OP_RD_HI 8'h28
`define SPD_OP_RD_LO 8'h20
`define SPD_OP_RD_EE 8'ha0
`define SPD_OP_RD_LOCK 8'h58
`define SPD_OP_RD_FUSE 8'h50
`define SPD_OP_RD_SIG 8'h30
`define SPD_OP_RD_CAL 8'h38
`define SPD_OP_WR_PAGE 8'h4c
`define SPD_OP_WR_EE 8'hc0
`define SPD_OP_WR_EEPAGE 8'hc2

// ****************************************
// second byte after the ac prefix, and selectors
// ****************************************
`define SPD_B2_ENABLE 8'h53
`define SPD_B2_ERASE 8'h80
`define SPD_B2_WR_LOCK 8'he0
`define SPD_B2_WR_FUSE_LO 8'ha0
`define SPD_B2_WR_FUSE_HI 8'ha8
`define SPD_B2_WR_FUSE_EXT 8'ha4
`define SPD_B2_HI_SEL 8'h08

// ****************************************
// reset values and read filler
// ****************************************
`define SPD_UNPROG 8'hff
`define SPD_ZERO 8'h00

// ****************************************
// timing: nanoseconds per clock, write times in microseconds
// ****************************************
`define SPD_CLK_NS 25
`define SPD_T_SHORT_US 4500
`define SPD_T_LONG_US 9000
`define SPD_CYC_SHORT ((`SPD_T_SHORT_US * 1000) / `SPD_CLK_NS)
`define SPD_CYC_LONG ((`SPD_T_LONG_US * 1000) / `SPD_CLK_NS)

`endif

// >>> spd_pkg.sv
// types for the serial programming command decoder
package spd_pkg;

   typedef enum logic [2:0] {
      SPD_OP_NONE,
      SPD_OP_FLASH_PAGE,
      SPD_OP_EE_BYTE,
      SPD_OP_EE_PAGE,
      SPD_OP_ERASE,
      SPD_OP_FUSE
   } spd_nv_op_t;

endpackage : spd_pkg

// >>> spd_link.sv
// serial link: pin synchronisers, edge detect, byte shifter
`timescale 1ns/1ps
module spd_link (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // pins
   input wire logic sck,
   input wire logic mosi,
   input wire logic prog_reset_n,
   output logic miso,
   // byte side
   input wire logic [7:0] tx_byte,
   input wire logic tx_load,
   output logic [7:0] rx_byte,
   output logic rx_done,
   output logic [1:0] byte_idx,
   output logic active
);
   typedef struct packed {
      logic [1:0] sck_s;
      logic [1:0] mosi_s;
      logic [1:0] rst_s;
      logic sck_prev;
      logic [7:0] shift;
      logic [2:0] bit_cnt;
      logic [1:0] byte_idx;
      logic [7:0] tx;
      logic miso;
      logic [7:0] rx;
      logic done;
   } spd_link_st_t;

   spd_link_st_t st_q;
   spd_link_st_t st_d;
   logic rise;
   logic fall;

   always_comb begin
      st_d = st_q;
      st_d.done = 1'b0;
      st_d.sck_s = {st_q.sck_s[0], sck};
      st_d.mosi_s = {st_q.mosi_s[0], mosi};
      st_d.rst_s = {st_q.rst_s[0], prog_reset_n};
      st_d.sck_prev = st_q.sck_s[1];
      rise = st_q.sck_s[1] & ~st_q.sck_prev;
      fall = ~st_q.sck_s[1] & st_q.sck_prev;
      if (tx_load) begin
         st_d.tx = tx_byte;
      end
      if (st_q.rst_s[1]) begin
         // device pin reset high: link idle, counters cleared to resync
         st_d.bit_cnt = 3'h0;
         st_d.byte_idx = 2'h0;
      end else begin
         if (rise) begin
            st_d.shift = {st_q.shift[6:0], st_q.mosi_s[1]};
            st_d.bit_cnt = st_q.bit_cnt + 3'h1;
            if (st_q.bit_cnt == 3'h7) begin
               st_d.rx = {st_q.shift[6:0], st_q.mosi_s[1]};
               st_d.done = 1'b1;
               st_d.byte_idx = st_q.byte_idx + 2'h1;
            end
         end
         if (fall) begin
            // msb first; first bit of a byte leaves on the falling edge ending the previous one
            st_d.miso = st_q.tx[3'h7 - st_q.bit_cnt];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign miso = st_q.miso;
   assign rx_byte = st_q.rx;
   assign rx_done = st_q.done;
   assign byte_idx = st_q.byte_idx;
   assign active = ~st_q.rst_s[1];
endmodule : spd_link

// >>> spd_timer.sv
// self-timed programming busy counter
`timescale 1ns/1ps
`include "spd_regs.svh"
module spd_timer #(
   parameter int unsigned SHORT_CYC = `SPD_CYC_SHORT,
   parameter int unsigned LONG_CYC = `SPD_CYC_LONG
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // control
   input wire logic start,
   input wire logic long_op,
   output logic busy
);
   typedef struct packed {
      logic [19:0] cnt;
   } spd_tmr_st_t;

   spd_tmr_st_t st_q;
   spd_tmr_st_t st_d;

   always_comb begin
      st_d = st_q;
      if (start) begin
         st_d.cnt = long_op ? LONG_CYC[19:0] : SHORT_CYC[19:0];
      end else if (st_q.cnt != 20'h0) begin
         st_d.cnt = st_q.cnt - 20'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign busy = (st_q.cnt != 20'h0);
endmodule : spd_timer

// >>> spd_decoder.sv
// four-byte serial programming instruction decoder
`timescale 1ns/1ps
`include "spd_regs.svh"

// What this block does
// - four-byte instructions; ac 53 enables programming, ac 80 erases flash and eeprom
// - poll f0 returns busy flag in bit 0 of the fourth byte
// - 4d 00 takes extended address from byte three
// - 48 and 40 load high or low page buffer byte at address
// - c1 loads eeprom page buffer at byte three address with data
// - 4c writes page buffer to flash at page address from bytes two and three
// - c0 writes one eeprom byte; c2 programs the eeprom page buffer
// - 28, 20, a0 return program high, low, eeprom byte in fourth slot
// - 58/50 with 00 or 08 return lock, low, high, extended fuses
// - 30 returns signature byte, 38 returns calibration byte by byte three
// - ac with e0, a0, a8, a4 writes lock, fuse low, high, extended
// - fuse and lock bits: zero programmed, one unprogrammed
// - when in sync, echo 53 while third enable byte shifts in
// - sample input on rising serial clock, change output on falling
// - reads inside a flash page being written return ff until ready
module spd_decoder #(
   parameter int unsigned SHORT_CYC = `SPD_CYC_SHORT,
   parameter int unsigned LONG_CYC = `SPD_CYC_LONG,
   parameter logic [7:0] SIG0 = 8'h3c, // arbitrary value
   parameter logic [7:0] SIG1 = 8'h11, // arbitrary value
   parameter logic [7:0] SIG2 = 8'h22, // arbitrary value
   parameter logic [7:0] CAL0 = 8'h80,
   parameter logic [7:0] CAL1 = 8'h81,
   parameter logic [7:0] CAL2 = 8'h82,
   parameter logic [7:0] CAL3 = 8'h83
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // programming pins
   input wire logic prog_reset_n,
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   // status
   output logic prog_enabled,
   output logic busy_poll_flag,
   output logic [7:0] ext_addr,
   output spd_pkg::spd_nv_op_t last_op
);
   import spd_pkg::*;

   // ****************************************
   // memories
   // ****************************************
   // small arrays: 16 k flash words is out of scope, address is folded
   localparam int AW = 8;
   localparam int PAGE_W = 6;
   logic [15:0] flash_mem [0:(1<<AW)-1];
   logic [7:0] ee_mem [0:(1<<AW)-1];
   logic [15:0] page_buf [0:(1<<PAGE_W)-1];
   logic [7:0] ee_buf [0:3];

   typedef struct packed {
      logic enabled;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] lock;
      logic [7:0] fuse_lo;
      logic [7:0] fuse_hi;
      logic [7:0] fuse_ext;
      logic [7:0] ext;
      logic [AW-1:0] wpage_base;
      logic page_pending;
      spd_nv_op_t op;
   } spd_st_t;

   spd_st_t st_q;
   spd_st_t st_d;

   logic [7:0] rx_byte;
   logic rx_done;
   logic [1:0] byte_idx;
   logic active;
   logic [7:0] tx_byte;
   logic tx_load;
   logic busy;
   logic start;
   logic long_op;

   // ****************************************
   // link and timer
   // ****************************************
   spd_link u_link (
      .clk(clk),
      .reset_n(reset_n),
      .sck(sck),
      .mosi(mosi),
      .prog_reset_n(prog_reset_n),
      .miso(miso),
      .tx_byte(tx_byte),
      .tx_load(tx_load),
      .rx_byte(rx_byte),
      .rx_done(rx_done),
      .byte_idx(byte_idx),
      .active(active)
   );

   spd_timer #(
      .SHORT_CYC(SHORT_CYC),
      .LONG_CYC(LONG_CYC)
   ) u_timer (
      .clk(clk),
      .reset_n(reset_n),
      .start(start),
      .long_op(long_op),
      .busy(busy)
   );

   // ****************************************
   // decode helpers
   // ****************************************
   function automatic logic is_fuse_sel(input logic [7:0] b2);
      return b2 == `SPD_B2_HI_SEL;
   endfunction : is_fuse_sel

   function automatic logic [AW-1:0] word_addr(input logic [7:0] hi, input logic [7:0] lo);
      return lo[AW-1:0] ^ hi[AW-1:0];
   endfunction : word_addr

   // word address of the page start, from 000a aaaa / aa00 0000
   function automatic logic [AW-1:0] page_base(input logic [7:0] b2, input logic [7:0] b3);
      logic [6:0] pg;
      pg = {b2[4:0], b3[7:6]};
      return {pg[1:0], 6'h00} ^ {3'h0, pg[6:2]};
   endfunction : page_base

   // ****************************************
   // reply byte for the next slot
   // ****************************************
   logic [AW-1:0] rd_addr;
   logic rd_blank;
   logic [7:0] reply;
   always_comb begin
      rd_addr = word_addr(st_q.b2, rx_byte);
      // flash reads inside the page under write return ff
      rd_blank = busy && st_q.page_pending && (rd_addr[AW-1:PAGE_W] == st_q.wpage_base[AW-1:PAGE_W]);
      reply = `SPD_ZERO;
      tx_load = 1'b0;
      if (rx_done) begin
         tx_load = 1'b1;
         case (byte_idx)
            2'h2: begin
               // byte two just arrived, byte three slot echoes it when in sync
               reply = rx_byte;
            end
            2'h3: begin
               case (st_q.b1)
                  `SPD_OP_POLL: reply = {7'h00, busy};
                  `SPD_OP_RD_HI: reply = rd_blank ? `SPD_UNPROG : flash_mem[rd_addr][15:8];
                  `SPD_OP_RD_LO: reply = rd_blank ? `SPD_UNPROG : flash_mem[rd_addr][7:0];
                  `SPD_OP_RD_EE: reply = (busy && st_q.op == SPD_OP_EE_BYTE) ? `SPD_UNPROG
                                        : ee_mem[rd_addr];
                  `SPD_OP_RD_LOCK: reply = is_fuse_sel(st_q.b2) ? st_q.fuse_hi : st_q.lock;
                  `SPD_OP_RD_FUSE: reply = is_fuse_sel(st_q.b2) ? st_q.fuse_ext : st_q.fuse_lo;
                  `SPD_OP_RD_SIG: begin
                     case (rx_byte[1:0])
                        2'h0: reply = SIG0;
                        2'h1: reply = SIG1;
                        2'h2: reply = SIG2;
                        default: reply = `SPD_UNPROG;
                     endcase
                  end
                  `SPD_OP_RD_CAL: begin
                     case (rx_byte[1:0])
                        2'h0: reply = CAL0;
                        2'h1: reply = CAL1;
                        2'h2: reply = CAL2;
                        default: reply = CAL3;
                     endcase
                  end
                  default: reply = `SPD_ZERO;
               endcase
               if (!st_q.enabled) begin
                  reply = `SPD_ZERO;
               end
            end
            default: reply = `SPD_ZERO;
         endcase
      end
      tx_byte = reply;
   end

   // ****************************************
   // instruction execution on the fourth byte
   // ****************************************
   logic exec;
   logic [AW-1:0] addr4;
   always_comb begin
      st_d = st_q;
      start = 1'b0;
      long_op = 1'b0;
      exec = rx_done && (byte_idx == 2'h0);
      addr4 = word_addr(st_q.b2, st_q.b3);
      if (!busy) begin
         st_d.page_pending = 1'b0;
      end
      if (!active) begin
         st_d.enabled = 1'b0;
      end
      if (rx_done) begin
         case (byte_idx)
            2'h1: st_d.b1 = rx_byte;
            2'h2: st_d.b2 = rx_byte;
            2'h3: st_d.b3 = rx_byte;
            default: st_d.b1 = st_q.b1;
         endcase
      end
      if (exec) begin
         if (st_q.b1 == `SPD_OP_PREFIX_AC && st_q.b2 == `SPD_B2_ENABLE) begin
            st_d.enabled = 1'b1;
         end else if (st_q.enabled && !busy) begin
            case (st_q.b1)
               `SPD_OP_PREFIX_AC: begin
                  case (st_q.b2)
                     `SPD_B2_ERASE: begin
                        st_d.op = SPD_OP_ERASE;
                        st_d.lock = `SPD_UNPROG;
                        start = 1'b1;
                        long_op = 1'b1;
                     end
                     `SPD_B2_WR_LOCK: begin
                        st_d.lock = rx_byte;
                        st_d.op = SPD_OP_FUSE;
                        start = 1'b1;
                     end
                     `SPD_B2_WR_FUSE_LO: begin
                        st_d.fuse_lo = rx_byte;
                        st_d.op = SPD_OP_FUSE;
                        start = 1'b1;
                     end
                     `SPD_B2_WR_FUSE_HI: begin
                        st_d.fuse_hi = rx_byte;
                        st_d.op = SPD_OP_FUSE;
                        start = 1'b1;
                     end
                     `SPD_B2_WR_FUSE_EXT: begin
                        st_d.fuse_ext = rx_byte;
                        st_d.op = SPD_OP_FUSE;
                        start = 1'b1;
                     end
                     default: st_d.op = st_q.op;
                  endcase
               end
               `SPD_OP_LOAD_EXT: st_d.ext = st_q.b3;
               `SPD_OP_WR_PAGE: begin
                  st_d.wpage_base = page_base(st_q.b2, st_q.b3);
                  st_d.page_pending = 1'b1;
                  st_d.op = SPD_OP_FLASH_PAGE;
                  start = 1'b1;
               end
               `SPD_OP_WR_EE, `SPD_OP_WR_EEPAGE: begin
                  st_d.op = (st_q.b1 == `SPD_OP_WR_EE) ? SPD_OP_EE_BYTE : SPD_OP_EE_PAGE;
                  start = 1'b1;
                  long_op = 1'b1;
               end
               default: st_d.op = st_q.op;
            endcase
         end
      end
   end

   // memory writes, kept apart from the struct since arrays are large
   always_ff @(posedge clk) begin
      if (exec && st_q.enabled && !busy) begin
         case (st_q.b1)
            `SPD_OP_LOAD_HI: page_buf[st_q.b3[PAGE_W-1:0]][15:8] <= rx_byte;
            `SPD_OP_LOAD_LO: page_buf[st_q.b3[PAGE_W-1:0]][7:0] <= rx_byte;
            `SPD_OP_LOAD_EE: ee_buf[st_q.b3[1:0]] <= rx_byte;
            `SPD_OP_WR_EE: ee_mem[addr4] <= rx_byte;
            `SPD_OP_WR_EEPAGE: begin
               for (int i = 0; i < 4; i++) begin
                  ee_mem[{addr4[AW-1:2], i[1:0]}] <= ee_buf[i];
               end
            end
            `SPD_OP_WR_PAGE: begin
               for (int i = 0; i < (1 << PAGE_W); i++) begin
                  // xor, not or: the fold leaves high page bits in the low word bits
                  flash_mem[page_base(st_q.b2, st_q.b3) ^ AW'(i)] <= page_buf[i];
               end
            end
            `SPD_OP_PREFIX_AC: begin
               if (st_q.b2 == `SPD_B2_ERASE) begin
                  for (int i = 0; i < (1 << AW); i++) begin
                     flash_mem[i] <= 16'hffff;
                     ee_mem[i] <= `SPD_UNPROG;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.lock <= `SPD_UNPROG;
         st_q.fuse_lo <= `SPD_UNPROG;
         st_q.fuse_hi <= `SPD_UNPROG;
         st_q.fuse_ext <= `SPD_UNPROG;
      end else begin
         st_q <= st_d;
      end
   end

   assign prog_enabled = st_q.enabled;
   assign busy_poll_flag = busy;
   assign ext_addr = st_q.ext;
   assign last_op = st_q.op;
endmodule : spd_decoder

// >>> spd_prog_model.sv
// programmer model: spi master on the serial programming pins
`timescale 1ns/1ps
module spd_prog_model (
   // clock
   input wire logic clk,
   // pins
   output logic sck,
   output logic mosi,
   input wire logic miso,
   // replies of byte slots three and four
   output logic [7:0] rsp3,
   output logic [7:0] rsp4,
   output logic rsp_valid
);
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      rsp_valid = 1'b0;
   end
   task automatic cmd(input logic [7:0] b1, b2, b3, b4, input bit chk);
      logic [31:0] tx;
      tx = {b1, b2, b3, b4};
      for (int i = 31; i >= 0; i--) begin
         mosi = tx[i];
         repeat (4) @(negedge clk);
         sck = 1'b1;
         repeat (4) @(negedge clk);
         // sampled late in the high phase: miso only moves after the fall
         {rsp3, rsp4} = {rsp3[6:0], rsp4, miso};
         sck = 1'b0;
      end
      // released data line flips so a held value is never mistaken for data
      mosi = ~mosi;
      rsp_valid = chk;
      @(negedge clk);
      rsp_valid = 1'b0;
   endtask : cmd
endmodule : spd_prog_model

// >>> spd_decoder_sva.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
`include "spd_regs.svh"
module spd_decoder_sva #(
   parameter int unsigned SHORT_CYC = `SPD_CYC_SHORT,
   parameter int unsigned LONG_CYC = `SPD_CYC_LONG
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // pins
   input wire logic prog_reset_n,
   input wire logic sck,
   input wire logic miso,
   // status
   input wire logic prog_enabled,
   input wire logic busy_poll_flag,
   input wire logic [7:0] ext_addr,
   input wire spd_pkg::spd_nv_op_t last_op
);
   import spd_pkg::*;
   int unsigned busy_cnt_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // length of the current busy stretch
   always_ff @(posedge clk) begin
      if (!reset_n || !busy_poll_flag) begin
         busy_cnt_q <= 0;
      end else begin
         busy_cnt_q <= busy_cnt_q + 1;
      end
   end
   a_reset_quiet: assert property (
      $rose(reset_n) |-> !miso && !prog_enabled && !busy_poll_flag)
      else $error("outputs not idle after reset");
   a_miso_after_fall: assert property (
      $changed(miso) && !prog_reset_n |-> !$past(sck, 2))
      else $error("miso moved outside the low serial clock phase");
   a_session_only: assert property (
      prog_reset_n [*6] |-> !prog_enabled)
      else $error("enable held outside a session");
   a_enable_on_rise: assert property (
      $rose(prog_enabled) |-> $past(sck, 3) || $past(sck, 4) || $past(sck, 5))
      else $error("enable not tied to a serial clock rise");
   a_busy_needs_en: assert property (
      $rose(busy_poll_flag) |-> prog_enabled && ($past(sck, 3) || $past(sck, 5)))
      else $error("write started without enable or off a rise");
   a_busy_max_time: assert property (
      busy_cnt_q <= LONG_CYC + 4)
      else $error("busy held too long");
   a_busy_min_time: assert property (
      $fell(busy_poll_flag) |-> busy_cnt_q + 2 >= SHORT_CYC)
      else $error("busy dropped too early");
   a_ext_addr_en: assert property (
      $changed(ext_addr) |-> prog_enabled)
      else $error("extended address changed while locked");
   a_op_starts_busy: assert property (
      $changed(last_op) |-> ##[0:2] busy_poll_flag)
      else $error("operation recorded without busy");
endmodule : spd_decoder_sva

// >>> tb.sv
// self-checking bench for the serial programming decoder
`timescale 1ns/1ps
module tb;
   import spd_pkg::*;
   localparam int unsigned SHORT_SIM = 400;
   localparam int unsigned LONG_SIM = 800;
   // arbitrary signature and calibration contents
   localparam logic [23:0] SIG_V = 24'h963c5a;
   localparam logic [31:0] CAL_V = 32'h44332211;
   // fuse write selectors and matching read opcode pairs
   localparam logic [31:0] WSEL = 32'he0a4a8a0;
   localparam logic [31:0] RB1 = 32'h58505850;
   localparam logic [31:0] RB2 = 32'h00080800;
   typedef struct {
      logic [7:0] val;
      bit use3;
   } spd_note_t;
   logic clk;
   logic reset_n;
   logic prog_reset_n;
   logic sck;
   logic mosi;
   logic miso;
   logic prog_enabled;
   logic busy_poll_flag;
   logic [7:0] ext_addr;
   spd_nv_op_t last_op;
   logic [7:0] rsp3;
   logic [7:0] rsp4;
   logic rsp_valid;
   logic [7:0] fuse_val [4];
   logic [7:0] d;
   logic [7:0] e;
   spd_note_t notes [$];
   spd_note_t nt;
   int miscompares = 0;
   int n_compared = 0;
   int seed = 71;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   spd_decoder #(
      .SHORT_CYC(SHORT_SIM), .LONG_CYC(LONG_SIM),
      .SIG0(SIG_V[7:0]), .SIG1(SIG_V[15:8]), .SIG2(SIG_V[23:16]),
      .CAL0(CAL_V[7:0]), .CAL1(CAL_V[15:8]), .CAL2(CAL_V[23:16]), .CAL3(CAL_V[31:24])
   ) dut_u (
      .clk(clk), .reset_n(reset_n), .prog_reset_n(prog_reset_n), .sck(sck), .mosi(mosi),
      .miso(miso), .prog_enabled(prog_enabled), .busy_poll_flag(busy_poll_flag),
      .ext_addr(ext_addr), .last_op(last_op)
   );
   spd_prog_model pm_u (
      .clk(clk), .sck(sck), .mosi(mosi), .miso(miso),
      .rsp3(rsp3), .rsp4(rsp4), .rsp_valid(rsp_valid)
   );
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic run(input logic [7:0] b1, b2, b3, b4, exp, input bit use3);
      notes.push_back('{exp, use3});
      pm_u.cmd(b1, b2, b3, b4, 1'b1);
   endtask : run
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         pm_u.cmd(8'hf0, 8'h00, 8'h00, 8'h00, 1'b0);
         n++;
      end while (rsp4[0] !== 1'b0 && n < 40);
      check("busy poll", rsp4, 8'h00);
   endtask : wait_ready
   task automatic test_done();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   // replies are matched in issue order
   always @(posedge clk) begin
      if (rsp_valid === 1'b1) begin
         nt = notes.pop_front();
         check("reply", nt.use3 ? rsp3 : rsp4, nt.val);
      end
   end
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      test_done();
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      reset_n = 1'b0;
      prog_reset_n = 1'b1;
      repeat (12) @(negedge clk);
      reset_n = 1'b1;
      prog_reset_n = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 4; i++) begin
         run(RB1[8*i +: 8], RB2[8*i +: 8], 8'h00, 8'h00, 8'h00, 1'b0);
      end
      run(8'hac, 8'h53, 8'h00, 8'h00, 8'h53, 1'b1);
      repeat (3) @(negedge clk);
      check("prog_enabled", prog_enabled, 8'h01);
      $display("test enable done");
      for (int i = 0; i < 4; i++) begin
         run(RB1[8*i +: 8], RB2[8*i +: 8], 8'h00, 8'h00, 8'hff, 1'b0);
         fuse_val[i] = 8'($random(seed)) | 8'hf0;
         pm_u.cmd(8'hac, WSEL[8*i +: 8], 8'h00, fuse_val[i], 1'b0);
         run(8'hf0, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0);
         wait_ready();
         check("last_op", last_op, SPD_OP_FUSE);
         run(RB1[8*i +: 8], RB2[8*i +: 8], 8'h00, 8'h00, fuse_val[i], 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         if (i < 3) begin
            run(8'h30, 8'h00, 8'(i), 8'h00, SIG_V[8*i +: 8], 1'b0);
         end
         run(8'h38, 8'h00, 8'(i), 8'h00, CAL_V[8*i +: 8], 1'b0);
      end
      $display("test fuses done");
      d = 8'($random(seed));
      e = 8'($random(seed));
      pm_u.cmd(8'h40, 8'h00, 8'h45, d, 1'b0);
      pm_u.cmd(8'h48, 8'h00, 8'h45, e, 1'b0);
      pm_u.cmd(8'h4c, 8'h00, 8'h40, 8'h00, 1'b0);
      run(8'h20, 8'h00, 8'h45, 8'h00, 8'hff, 1'b0);
      wait_ready();
      check("last_op", last_op, SPD_OP_FLASH_PAGE);
      run(8'h20, 8'h00, 8'h45, 8'h00, d, 1'b0);
      run(8'h28, 8'h00, 8'h45, 8'h00, e, 1'b0);
      pm_u.cmd(8'hc0, 8'h00, 8'h10, d, 1'b0);
      run(8'ha0, 8'h00, 8'h10, 8'h00, 8'hff, 1'b0);
      wait_ready();
      check("last_op", last_op, SPD_OP_EE_BYTE);
      run(8'ha0, 8'h00, 8'h10, 8'h00, d, 1'b0);
      for (int i = 0; i < 4; i++) begin
         pm_u.cmd(8'hc1, 8'h00, 8'(i), 8'h30 + 8'(i), 1'b0);
      end
      pm_u.cmd(8'hc2, 8'h00, 8'h00, 8'h00, 1'b0);
      check("last_op", last_op, SPD_OP_EE_PAGE);
      wait_ready();
      for (int i = 0; i < 4; i++) begin
         run(8'ha0, 8'h00, 8'(i), 8'h00, 8'h30 + 8'(i), 1'b0);
      end
      $display("test memory done");
      pm_u.cmd(8'h4d, 8'h00, e, 8'h00, 1'b0);
      repeat (3) @(negedge clk);
      check("ext_addr", ext_addr, e);
      pm_u.cmd(8'hac, 8'h80, 8'h00, 8'h00, 1'b0);
      wait_ready();
      check("last_op", last_op, SPD_OP_ERASE);
      run(8'h58, 8'h00, 8'h00, 8'h00, 8'hff, 1'b0);
      run(8'h20, 8'h00, 8'h45, 8'h00, 8'hff, 1'b0);
      run(8'h50, 8'h00, 8'h00, 8'h00, fuse_val[0], 1'b0);
      $display("test erase done");
      prog_reset_n = 1'b1;
      repeat (8) @(negedge clk);
      check("prog_enabled", prog_enabled, 8'h00);
      prog_reset_n = 1'b0;
      repeat (4) @(negedge clk);
      run(8'h28, 8'h00, 8'h45, 8'h00, 8'h00, 1'b0);
      repeat (4) @(negedge clk);
      $display("test session done");
      test_done();
   end
endmodule : tb

bind spd_decoder spd_decoder_sva #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) chk_u (
   .clk(clk), .reset_n(reset_n), .prog_reset_n(prog_reset_n), .sck(sck), .miso(miso),
   .prog_enabled(prog_enabled), .busy_poll_flag(busy_poll_flag),
   .ext_addr(ext_addr), .last_op(last_op)
);
